/* src/lane_mapper_params.svh */
// timing counts, per-mode dividers and sizes for the lane mapper
`ifndef LANE_MAPPER_PARAMS_SVH
`define LANE_MAPPER_PARAMS_SVH
`define LM_SAMPLE_W 8
`define LM_LANES 8
`define LM_FIFO_DEPTH 16
`define LM_CODE_MAX 8'hFF
`define LM_CODE_MIN 8'h00
`define LM_DIV_SINGLE 4'h1
`define LM_DIV_DUAL 4'h2
`define LM_DIV_QUAD 4'h4
`define LM_GAIN_UNITY 16'h8000
`define LM_GAIN_FRAC 15
`define LM_BIT_LAST 3'h7
`define LM_FRAME_HALF 3'h3
`endif

/* src/lane_mapper_pkg.sv */
// types shared by the lane mapper files
package lane_mapper_pkg;
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_DUAL,
        MODE_QUAD
    } op_mode_t;

    typedef struct packed {
        logic [7:0] code;
        logic [2:0] branch;
    } branch_sample_t;

    typedef struct packed {
        logic [7:0] laneOneA;
        logic [7:0] laneOneB;
        logic [7:0] laneTwoA;
        logic [7:0] laneTwoB;
        logic [7:0] laneThreeA;
        logic [7:0] laneThreeB;
        logic [7:0] laneFourA;
        logic [7:0] laneFourB;
    } lane_frame_t;
endpackage

/* src/sample_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // fill side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // drain side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    logic doWrite;
    logic doRead;

    assign inReady = (count_ff != (AW+1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign outData = mem_ff[rdPtr_ff];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    always_ff @(posedge clk_sys) begin
        if (doWrite) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            // pointers wrap to zero after DEPTH-1, for any depth
            if (doWrite) begin
                wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (doRead) begin
                rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
            end
            if (doWrite && !doRead) begin
                count_ff <= count_ff + 1'b1;
            end else if (doRead && !doWrite) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule // sample_fifo

/* src/interleaved_sample_lane_mapper.sv */
// interleaved sample lane mapper: branch samples to eight serial lanes
//
// Overview of operation
// - eight branches, modes group them, per-branch gain
// - frame and bit clocks generated internally
// - only rising edge of input clock used
// - unsigned binary output, codes 0 to 255
// - mode sets divider and interleaving arrangement
// - quad mode: channel n on lanes nA, nB
// - dual mode: branches 1,3,2,4 and 5,7,6,8
// - single mode: branches 1,6,2,5,8,3,7,4
// - corrected codes, every code reachable
`timescale 1ns/1ns
`include "lane_mapper_params.svh"
module interleaved_sample_lane_mapper
    import lane_mapper_pkg::*;
#(
    parameter int LANES = `LM_LANES,
    parameter int FIFO_DEPTH = `LM_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // control pins from outside the clock domain
    input wire logic powerDown,
    input wire logic [1:0] modeSelect,
    // per-branch fine gain, unsigned 1.15
    input wire logic [LANES*16-1:0] fineGain,
    // branch conversions, index = branch number minus one
    input wire logic [LANES*8-1:0] branchCode,
    input wire logic branchValid,
    output logic branchReady,
    // serial output side
    output logic frame_clock_out,
    output logic bit_clock_out,
    output logic lane_one_a,
    output logic lane_one_b,
    output logic lane_two_a,
    output logic lane_two_b,
    output logic lane_three_a,
    output logic lane_three_b,
    output logic lane_four_a,
    output logic lane_four_b
);
    logic [1:0] pdSync_ff;
    logic [1:0] modeSync0_ff;
    logic [1:0] modeSync1_ff;
    op_mode_t mode_ff;
    logic [3:0] divCount_ff;
    logic sampleTick;
    logic [2:0] bitCount_ff;
    logic bitPhase_ff;
    logic [63:0] shift_ff;
    logic frameClk_ff;
    logic bitClk_ff;
    logic [7:0] laneOut_ff;
    logic branchReady_ff;
    lane_frame_t mapped;
    lane_frame_t fifoIn;
    lane_frame_t fifoOut;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoPop;
    logic loadFrame;
    localparam int FW = $clog2(FIFO_DEPTH) + 1;
    logic fifoPush;
    logic [FW-1:0] fill_ff;
    logic [FW-1:0] nxtFill;

    // corrected code: saturate so both ends stay reachable
    function automatic logic [7:0] correct_code(input logic [8:0] raw);
        logic [7:0] code;
        code = raw[7:0];
        if (raw > 9'(`LM_CODE_MAX)) begin
            code = `LM_CODE_MAX;
        end
        return code;
    endfunction

    // gain one branch code, rounded to nearest
    function automatic logic [7:0] apply_gain(input logic [7:0] code, input logic [15:0] gain);
        logic [23:0] prod;
        logic [8:0] rounded;
        prod = code * gain;
        rounded = 9'((prod + 24'(1 << (`LM_GAIN_FRAC - 1))) >> `LM_GAIN_FRAC);
        // unsigned code range 0 to 255
        return correct_code(rounded);
    endfunction

    function automatic logic [7:0] branch_out(input logic [63:0] codes,
                                                input logic [127:0] gains, input int br);
        return apply_gain(codes[(br-1)*8 +: 8], gains[(br-1)*16 +: 16]);
    endfunction

    // frame clock high over the first half of each frame
    function automatic logic frame_high(input logic [2:0] count);
        return (count == `LM_BIT_LAST) || (count < `LM_FRAME_HALF);
    endfunction

    // two-flop synchronisers on the pins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pdSync_ff <= 2'h3;
            modeSync0_ff <= 2'h0;
            modeSync1_ff <= 2'h0;
        end else begin
            pdSync_ff <= {pdSync_ff[0], powerDown};
            modeSync0_ff <= modeSelect;
            modeSync1_ff <= modeSync0_ff;
        end
    end

    // mode only latched while powered down
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= MODE_SINGLE;
        end else if (pdSync_ff[1]) begin
            case (modeSync1_ff)
                2'h1: mode_ff <= MODE_DUAL;
                2'h2: mode_ff <= MODE_QUAD;
                // code 3 falls back to single channel
                default: mode_ff <= MODE_SINGLE;
            endcase
        end
    end

    function automatic logic [3:0] div_of(input op_mode_t m);
        case (m)
            MODE_DUAL: return `LM_DIV_DUAL;
            MODE_QUAD: return `LM_DIV_QUAD;
            default: return `LM_DIV_SINGLE;
        endcase
    endfunction

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            divCount_ff <= 4'h0;
        end else if (pdSync_ff[1] || divCount_ff >= div_of(mode_ff) - 4'h1) begin
            divCount_ff <= 4'h0;
        end else begin
            divCount_ff <= divCount_ff + 4'h1;
        end
    end
    // one tick per divider period, none while powered down
    assign sampleTick = !pdSync_ff[1] && (divCount_ff == 4'h0);

    always_comb begin
        case (mode_ff)
            MODE_QUAD: begin
                mapped.laneOneA = branch_out(branchCode, fineGain, 1);
                mapped.laneOneB = branch_out(branchCode, fineGain, 2);
                mapped.laneTwoA = branch_out(branchCode, fineGain, 3);
                mapped.laneTwoB = branch_out(branchCode, fineGain, 4);
                mapped.laneThreeA = branch_out(branchCode, fineGain, 5);
                mapped.laneThreeB = branch_out(branchCode, fineGain, 6);
                mapped.laneFourA = branch_out(branchCode, fineGain, 7);
                mapped.laneFourB = branch_out(branchCode, fineGain, 8);
            end
            MODE_DUAL: begin
                mapped.laneOneA = branch_out(branchCode, fineGain, 1);
                mapped.laneOneB = branch_out(branchCode, fineGain, 3);
                mapped.laneTwoA = branch_out(branchCode, fineGain, 2);
                mapped.laneTwoB = branch_out(branchCode, fineGain, 4);
                mapped.laneThreeA = branch_out(branchCode, fineGain, 5);
                mapped.laneThreeB = branch_out(branchCode, fineGain, 7);
                mapped.laneFourA = branch_out(branchCode, fineGain, 6);
                mapped.laneFourB = branch_out(branchCode, fineGain, 8);
            end
            default: begin
                mapped.laneOneA = branch_out(branchCode, fineGain, 1);
                mapped.laneOneB = branch_out(branchCode, fineGain, 6);
                mapped.laneTwoA = branch_out(branchCode, fineGain, 2);
                mapped.laneTwoB = branch_out(branchCode, fineGain, 5);
                mapped.laneThreeA = branch_out(branchCode, fineGain, 8);
                mapped.laneThreeB = branch_out(branchCode, fineGain, 3);
                mapped.laneFourA = branch_out(branchCode, fineGain, 7);
                mapped.laneFourB = branch_out(branchCode, fineGain, 4);
            end
        endcase
    end
    assign fifoIn = mapped;

    // occupancy after this edge; ready must never promise a slot that is gone
    always_comb begin
        nxtFill = fill_ff;
        if (fifoPush && !fifoPop) begin
            nxtFill = fill_ff + 1'b1;
        end else if (fifoPop && !fifoPush) begin
            nxtFill = fill_ff - 1'b1;
        end
    end

    // mirrors the fifo count
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fill_ff <= '0;
        end else begin
            fill_ff <= nxtFill;
        end
    end

    // back-pressure: registered ready looks one edge ahead of the fifo
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            branchReady_ff <= 1'b0;
        end else begin
            branchReady_ff <= (nxtFill != FW'(FIFO_DEPTH)) && !pdSync_ff[1];
        end
    end
    assign branchReady = branchReady_ff;
    assign fifoPush = branchValid && branchReady_ff && sampleTick && fifoInReady;

    sample_fifo #(
        .WIDTH($bits(lane_frame_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .inData(fifoIn),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .outData(fifoOut),
        .outValid(fifoOutValid),
        .outReady(fifoPop)
    );

    // frame ends after 8 bits of two half-phases each
    assign loadFrame = (bitCount_ff == `LM_BIT_LAST) && bitPhase_ff;
    assign fifoPop = loadFrame && fifoOutValid;

    // bit clock: half rate toggle; frame clock high for first half
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bitPhase_ff <= 1'b0;
            bitCount_ff <= `LM_BIT_LAST;
            bitClk_ff <= 1'b0;
            frameClk_ff <= 1'b0;
        end else begin
            bitPhase_ff <= !bitPhase_ff;
            bitClk_ff <= !bitPhase_ff;
            if (bitPhase_ff) begin
                bitCount_ff <= bitCount_ff + 3'h1;
                frameClk_ff <= frame_high(bitCount_ff);
            end
        end
    end

    // serialiser: msb first on every lane; idle frames send zero code
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            shift_ff <= 64'h0;
        end else if (loadFrame) begin
            // empty fifo sends zero code rather than stale bits
            if (fifoOutValid) begin
                shift_ff <= fifoOut;
            end else begin
                shift_ff <= 64'h0;
            end
        end else if (bitPhase_ff) begin
            for (int i = 0; i < 8; i++) begin
                shift_ff[i*8 +: 8] <= {shift_ff[i*8 +: 7], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            laneOut_ff <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                // first bit leaves with the load so no bit cell is lost
                if (loadFrame) begin
                    laneOut_ff[i] <= fifoOutValid ? fifoOut[i*8+7] : 1'b0;
                end else if (bitPhase_ff) begin
                    laneOut_ff[i] <= shift_ff[i*8+6];
                end else begin
                    laneOut_ff[i] <= shift_ff[i*8+7];
                end
            end
        end
    end

    assign frame_clock_out = frameClk_ff;
    assign bit_clock_out = bitClk_ff;
    assign lane_one_a = laneOut_ff[7];
    assign lane_one_b = laneOut_ff[6];
    assign lane_two_a = laneOut_ff[5];
    assign lane_two_b = laneOut_ff[4];
    assign lane_three_a = laneOut_ff[3];
    assign lane_three_b = laneOut_ff[2];
    assign lane_four_a = laneOut_ff[1];
    assign lane_four_b = laneOut_ff[0];
endmodule // interleaved_sample_lane_mapper

/* verification/lane_mapper_properties.sv */
// assertions on serial timing and ready of the lane mapper
`timescale 1ns/1ns
module lane_mapper_properties (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // handshake
    input wire logic powerDown,
    input wire logic branchReady,
    // serial side
    input wire logic frame_clock_out,
    input wire logic bit_clock_out,
    input wire logic lane_one_a,
    input wire logic lane_one_b,
    input wire logic lane_two_a,
    input wire logic lane_two_b,
    input wire logic lane_three_a,
    input wire logic lane_three_b,
    input wire logic lane_four_a,
    input wire logic lane_four_b
);
    logic [7:0] laneBits;
    logic [1:0] upCnt_ff;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    assign laneBits = {lane_one_a, lane_one_b, lane_two_a, lane_two_b,
                       lane_three_a, lane_three_b, lane_four_a, lane_four_b};
    // first edges still show reset values
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            upCnt_ff <= 2'h0;
        end else if (upCnt_ff != 2'h3) begin
            upCnt_ff <= upCnt_ff + 2'h1;
        end
    end
    chk_bitclk_toggle: assert property (
        upCnt_ff == 2'h3 |-> bit_clock_out != $past(bit_clock_out))
        else $error("bit clock stalled");
    chk_frame_period: assert property (
        $rose(frame_clock_out) |-> ##16 $rose(frame_clock_out))
        else $error("frame period wrong");
    chk_frame_high: assert property (
        $rose(frame_clock_out) |-> frame_clock_out [*8] ##1 !frame_clock_out)
        else $error("frame high span wrong");
    chk_frame_low: assert property (
        $fell(frame_clock_out) |-> (!frame_clock_out) [*8] ##1 frame_clock_out)
        else $error("frame low span wrong");
    chk_lane_bit_pairs: assert property (
        $rose(frame_clock_out) |-> ##1 $stable(laneBits) ##2 $stable(laneBits)
        ##2 $stable(laneBits) ##2 $stable(laneBits))
        else $error("lane bit did not stand two cycles");
    chk_ready_down: assert property (
        powerDown [*4] |-> !branchReady)
        else $error("ready while powered down");
    chk_ready_reset: assert property (
        $rose(rst_b) |-> (!branchReady) [*3])
        else $error("ready too early after reset");
    chk_idle_lanes: assert property (
        $rose(rst_b) |-> (laneBits == 8'h00) [*8])
        else $error("lanes not idle after reset");
endmodule // lane_mapper_properties
bind interleaved_sample_lane_mapper lane_mapper_properties chk_u (
    .clk_sys, .rst_b, .powerDown, .branchReady, .frame_clock_out, .bit_clock_out,
    .lane_one_a, .lane_one_b, .lane_two_a, .lane_two_b,
    .lane_three_a, .lane_three_b, .lane_four_a, .lane_four_b);

/* verification/lane_receiver_model.sv */
// receiver model: deserialises one word per lane each frame
`timescale 1ns/1ns
module lane_receiver_model
    import lane_mapper_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // serial side
    input wire logic frame_clock_out,
    input wire logic [7:0] laneBits,
    // rebuilt frame
    output lane_frame_t frameWord,
    output logic frameValid
);
    logic fcoPrev = 1'b0;
    logic [3:0] phase = 4'h0;
    logic [7:0] acc [8];
    // one word per lane each frame
    assign frameWord = {acc[0], acc[1], acc[2], acc[3], acc[4], acc[5], acc[6], acc[7]};
    // frame start, then a bit every second rising edge
    always @(posedge clk_sys) begin
        fcoPrev <= frame_clock_out;
        frameValid <= (phase == 4'hE);
        if (frame_clock_out && !fcoPrev) begin
            phase <= 4'h1;
        end else if (phase != 4'h0) begin
            phase <= (phase == 4'hE) ? 4'h0 : phase + 4'h1;
        end
        if ((frame_clock_out && !fcoPrev) || (phase != 4'h0 && !phase[0])) begin
            for (int i = 0; i < 8; i++) begin
                acc[i] <= {acc[i][6:0], laneBits[7-i]};
            end
        end
    end
endmodule // lane_receiver_model

/* verification/test_interleaved_sample_lane_mapper.sv */
// self-checking bench for the lane mapper
`timescale 1ns/1ns
module test_interleaved_sample_lane_mapper
    import lane_mapper_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic powerDown = 1'b1;
    logic [1:0] modeSelect = 2'h0;
    logic [127:0] fineGain = {8{16'h8000}};
    logic [63:0] branchCode = 64'h0;
    logic branchValid = 1'b0;
    logic branchReady, frame_clock_out, bit_clock_out, rxValid;
    wire [7:0] lanes;
    lane_frame_t rxWord;
    int nFail = 0;
    int testsRun = 0;
    always #25 clk_sys = ~clk_sys;
    interleaved_sample_lane_mapper dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .powerDown(powerDown), .modeSelect(modeSelect),
        .fineGain(fineGain), .branchCode(branchCode), .branchValid(branchValid),
        .branchReady(branchReady), .frame_clock_out(frame_clock_out),
        .bit_clock_out(bit_clock_out), .lane_one_a(lanes[7]), .lane_one_b(lanes[6]),
        .lane_two_a(lanes[5]), .lane_two_b(lanes[4]), .lane_three_a(lanes[3]),
        .lane_three_b(lanes[2]), .lane_four_a(lanes[1]), .lane_four_b(lanes[0]));
    lane_receiver_model rx_u (.clk_sys(clk_sys), .frame_clock_out(frame_clock_out),
        .laneBits(lanes), .frameWord(rxWord), .frameValid(rxValid));
    task automatic complete_run;
        if (nFail == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
        for (int j = 0; j < 8; j++) begin
            check8(got[63-8*j -: 8], exp[63-8*j -: 8]);
        end
    endtask
    task automatic next_frame(output lane_frame_t w);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rxValid !== 1'b1 && n < 40);
        w = rxWord;
        check8({7'h0, rxValid}, 8'h01);
    endtask
    // mode is only taken while powered down
    task automatic set_mode(input logic [1:0] m);
        powerDown <= 1'b1;
        modeSelect <= m;
        repeat (6) @(posedge clk_sys);
        powerDown <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic run_mode(input logic [1:0] m, input int hold, input logic [63:0] code,
                            input logic [63:0] exp);
        lane_frame_t w;
        w = '0;
        set_mode(m);
        branchCode <= code;
        branchValid <= 1'b1;
        // off-tick refusal is silent, so hold exactly one divider period
        repeat (hold) @(posedge clk_sys);
        branchValid <= 1'b0;
        for (int k = 0; k < 4 && w === 64'h0; k++) begin
            next_frame(w);
        end
        cmp_word(w, exp);
    endtask
    task automatic fill_drain;
        lane_frame_t w;
        int taken;
        int seen;
        taken = 0;
        seen = 0;
        w = '1;
        set_mode(2'h0);
        branchValid <= 1'b1;
        do begin
            @(posedge clk_sys);
            taken += branchReady;
            seen += (rxValid === 1'b1 && rxWord !== 64'h0);
        end while (branchReady === 1'b1 && taken < 40);
        branchValid <= 1'b0;
        check8(8'(taken >= 16 && taken <= 19), 8'h01);
        while (w !== 64'h0 && seen < 40) begin
            next_frame(w);
            seen += (w !== 64'h0);
        end
        check8(8'(seen), 8'(taken));
    endtask
    task automatic idle_after_reset;
        lane_frame_t w;
        next_frame(w);
        cmp_word(w, 64'h0);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        idle_after_reset;
        run_mode(2'h2, 4, 64'h8877665544332211, 64'h1122334455667788);
        run_mode(2'h1, 2, 64'h8877665544332211, 64'h1133224455776688);
        run_mode(2'h0, 1, 64'h8877665544332211, 64'h1166225588337744);
        run_mode(2'h3, 1, 64'h8877665544332211, 64'h1166225588337744);
        fineGain[31:0] <= 32'hFFFF4000;
        run_mode(2'h2, 4, 64'h112233447F00FF80, 64'h40FF007F44332211);
        fineGain <= {8{16'h8000}};
        fill_drain;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        nFail++;
        complete_run;
    end
endmodule // test_interleaved_sample_lane_mapper
